/* File: rtl/cpr_cfg.svh */
// Constants for the clock, power and reset controller.
`ifndef CPR_CFG_SVH
`define CPR_CFG_SVH

// ----------------------------------------------------------------------------
// Addresses and reset values
// ----------------------------------------------------------------------------
`define CPR_START_ADDRESS 16'h8000
`define CPR_VECTOR_RESET 16'h0000

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define CPR_WARMUP_CYCLES 65536
`define CPR_WDOG_PULSE 4'h8
`define CPR_DIV256_LIMIT 8'hFF

// ----------------------------------------------------------------------------
// Interrupt source layout and fast divide select
// ----------------------------------------------------------------------------
`define CPR_SRC_COUNT 17
`define CPR_MOD_COUNT 8
`define CPR_SRC_EXT_LO 1
`define CPR_SRC_EXT_HI 3
`define CPR_SRC_TOD 4
`define CPR_DIV_FAST 2'h0

`endif

/* File: rtl/cpr_pkg.sv */
// Types shared by the clock, power and reset controller.
package cpr_pkg;
  typedef enum logic [1:0] {
    ST_WARMUP,
    ST_RESET_HOLD,
    ST_RUN,
    ST_STOP
  } ctl_state_type;
endpackage : cpr_pkg

/* File: rtl/warmup_if.sv */
// Handshake between the controller and its crystal warm-up counter.
`timescale 1ns/10ps
`default_nettype none
interface warmup_if;
  logic start;
  logic busy;
  logic done;
  modport ctrl (output start, input busy, input done);
  modport counter (input start, output busy, output done);
endinterface : warmup_if
`default_nettype wire

/* File: rtl/osc_warmup.sv */
// Crystal warm-up counter: busy for a fixed number of oscillator cycles.
`timescale 1ns/10ps
`default_nettype none
module osc_warmup #(
  parameter int WARMUP_CYCLES = 65536
) (
  input wire logic clock,
  input wire logic rstn,
  warmup_if.counter warm
);

  logic [16:0] count;

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  // A restart while busy reloads, so the crystal always gets a full period.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= 17'h00000;
      warm.busy <= 1'b0;
      warm.done <= 1'b0;
    end else if (warm.start) begin
      count <= 17'(WARMUP_CYCLES - 1);
      warm.busy <= 1'b1;
      warm.done <= 1'b0;
    end else if (warm.busy && count == 17'h00000) begin
      warm.busy <= 1'b0;
      warm.done <= 1'b1;
    end else begin
      count <= warm.busy ? count - 17'h00001 : count;
      warm.done <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_warm_start: assert property (@(posedge clock) disable iff (!rstn)
    warm.start |=> warm.busy && !warm.done) else $error("warm-up did not start");
  a_warm_done: assert property (@(posedge clock) disable iff (!rstn)
    warm.done |-> !warm.busy && $past(count) == 17'h00000)
    else $error("warm-up ended early");

endmodule : osc_warmup
`default_nettype wire

/* File: rtl/clock_power_reset_control.sv */
// Clock divide, stop mode, interrupt flagging and reset sequencing.
// Function
// - Hold off the crystal clock for 65,536 cycles after power-on and after each stop.
// - Clock divide select gives 1, 2, 4 or 8 oscillator cycles per tick.
// - Low-power enable with divide select 00b gives one tick per 256.
// - Switchback lets an enabled interrupt leave divide-by-256 mode.
// - Halt request enters stop: oscillator, clock and execution stop.
// - Stop ends on enabled external interrupt, reset pin or alarm.
// - In stop the RTC runs; the display runs only on the 32kHz source.
// - A source flag sets even when that source is disabled.
// - Interrupt request needs global, module and source enables.
// - One shared vector register that resets to 0000h.
// - Identify register shows which module holds a pending interrupt.
// - Seventeen sources: watchdog, external, RTC, serial and timers.
// - In reset, execution halts while both oscillators keep running.
// - Internal reset causes drive the external reset pin low.
// - Power-on reset returns every register here to its reset value.
// - Power-on reset sets the power-on flag, watchdog control bit 7.
// - After any reset, execution begins at address 8000h.
// - Pin held low keeps reset; release resumes execution.
`timescale 1ns/10ps
`default_nettype none
`include "cpr_cfg.svh"
module clock_power_reset_control #(
  parameter int WARMUP_CYCLES = `CPR_WARMUP_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clock_config_write,
  input wire logic [1:0] clock_divide_select_in,
  input wire logic low_power_divide_enable_in,
  input wire logic switchback_enable,
  input wire logic halt_request,
  input wire logic display_clock_source_select,
  input wire logic [16:0] source_event,
  input wire logic [16:0] source_enable,
  input wire logic [7:0] module_enable,
  input wire logic global_enable,
  input wire logic [16:0] flag_clear,
  input wire logic vector_write,
  input wire logic [15:0] vector_data,
  input wire logic watchdog_reset_request,
  input wire logic reset_pin_in,
  input wire logic por_flag_clear,
  output logic [1:0] clock_divide_select,
  output logic low_power_divide_enable,
  output logic divide256_mode,
  output logic sys_tick,
  output logic execution_enable,
  output logic cpu_reset,
  output logic osc_enable,
  output logic rtc_run,
  output logic display_run,
  output logic [16:0] interrupt_flags,
  output logic interrupt_request,
  output logic [7:0] interrupt_source_identify,
  output logic [15:0] interrupt_vector_address,
  output logic exec_start,
  output logic [15:0] start_address,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic por_flag
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  function automatic logic [2:0] module_of(input int src);
    if (src == 0) return 3'h0;
    else if (src <= `CPR_SRC_EXT_HI) return 3'h1;
    else if (src <= 5) return 3'h2;
    else if (src <= 7) return 3'h3;
    else if (src <= 9) return 3'h4;
    else if (src == 10) return 3'h5;
    else if (src <= 12) return 3'h6;
    else return 3'h7;
  endfunction : module_of
  function automatic logic [7:0] tick_limit(input logic [1:0] sel, input logic lpde);
    if (lpde && sel == `CPR_DIV_FAST) return `CPR_DIV256_LIMIT;
    return 8'((9'h001 << sel) - 9'h001);
  endfunction : tick_limit

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  cpr_pkg::ctl_state_type state;
  warmup_if warm ();
  logic boot;
  logic hold_reset;
  logic por_active;
  logic [3:0] wd_stretch;
  logic [7:0] div_count;
  logic stop_wake;
  logic [16:0] module_mask;
  logic [16:0] pending;
  logic [7:0] module_pending;
  logic [16:0] warm_len;
  osc_warmup #(.WARMUP_CYCLES(WARMUP_CYCLES)) warmup_counter (
    .clock(clock),
    .rstn(rstn),
    .warm(warm)
  );
  // --------------------------------------------------------------------------
  // Sequencing
  // --------------------------------------------------------------------------
  assign stop_wake = |(source_event[`CPR_SRC_EXT_HI:`CPR_SRC_EXT_LO]
                       & source_enable[`CPR_SRC_EXT_HI:`CPR_SRC_EXT_LO])
                     | source_event[`CPR_SRC_TOD] | !reset_pin_in;
  assign warm.start = boot || (state == cpr_pkg::ST_STOP && stop_wake);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      boot <= 1'b1;
    end else begin
      boot <= 1'b0;
    end
  end

  // The power-on path warms the crystal first, then waits out the reset pin.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= cpr_pkg::ST_WARMUP;
      hold_reset <= 1'b1;
    end else begin
      case (state)
        cpr_pkg::ST_RUN: begin
          if (watchdog_reset_request || !reset_pin_in) begin
            state <= cpr_pkg::ST_RESET_HOLD;
          end else if (halt_request) begin
            state <= cpr_pkg::ST_STOP;
          end
        end
        cpr_pkg::ST_STOP: begin
          if (stop_wake) begin
            state <= cpr_pkg::ST_WARMUP;
            hold_reset <= !reset_pin_in;
          end
        end
        cpr_pkg::ST_WARMUP: begin
          if (warm.done) begin
            state <= hold_reset ? cpr_pkg::ST_RESET_HOLD : cpr_pkg::ST_RUN;
          end
        end
        cpr_pkg::ST_RESET_HOLD: begin
          if (reset_pin_in && wd_stretch == 4'h0 && !por_active) begin
            state <= cpr_pkg::ST_RUN;
            hold_reset <= 1'b0;
          end
        end
        default: begin
          state <= cpr_pkg::ST_RESET_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      por_active <= 1'b1;
    end else if (warm.done) begin
      por_active <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wd_stretch <= 4'h0;
    end else if (state == cpr_pkg::ST_RUN && watchdog_reset_request) begin
      wd_stretch <= `CPR_WDOG_PULSE;
    end else if (wd_stretch != 4'h0) begin
      wd_stretch <= wd_stretch - 4'h1;
    end
  end

  // Internal causes pull the shared pin low; the pin is then read back.
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = por_active || wd_stretch != 4'h0;
  assign cpu_reset = state == cpr_pkg::ST_RESET_HOLD
                     || (state == cpr_pkg::ST_WARMUP && hold_reset);
  assign execution_enable = state == cpr_pkg::ST_RUN;
  assign osc_enable = state != cpr_pkg::ST_STOP;
  assign rtc_run = 1'b1;
  assign display_run = state != cpr_pkg::ST_STOP || !display_clock_source_select;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      exec_start <= 1'b0;
      start_address <= `CPR_START_ADDRESS;
    end else begin
      exec_start <= state == cpr_pkg::ST_RESET_HOLD && reset_pin_in
                    && wd_stretch == 4'h0 && !por_active;
      start_address <= `CPR_START_ADDRESS;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      por_flag <= 1'b1;
    end else if (por_flag_clear) begin
      por_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Clock divide
  // --------------------------------------------------------------------------
  assign divide256_mode = low_power_divide_enable && clock_divide_select == `CPR_DIV_FAST;
  // Switchback beats a same-cycle software write so a wake is never lost.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clock_divide_select <= `CPR_DIV_FAST;
      low_power_divide_enable <= 1'b0;
    end else if (state == cpr_pkg::ST_RESET_HOLD) begin
      clock_divide_select <= `CPR_DIV_FAST;
      low_power_divide_enable <= 1'b0;
    end else if (switchback_enable && divide256_mode && interrupt_request) begin
      low_power_divide_enable <= 1'b0;
    end else if (clock_config_write) begin
      clock_divide_select <= clock_divide_select_in;
      low_power_divide_enable <= low_power_divide_enable_in;
    end
  end

  // The tick stays low outside run, so warm-up and stop gate the clock.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_count <= 8'h00;
      sys_tick <= 1'b0;
    end else if (state != cpr_pkg::ST_RUN) begin
      div_count <= 8'h00;
      sys_tick <= 1'b0;
    end else if (div_count >= tick_limit(clock_divide_select, low_power_divide_enable)) begin
      div_count <= 8'h00;
      sys_tick <= 1'b1;
    end else begin
      div_count <= div_count + 8'h01;
      sys_tick <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  always_comb begin
    module_mask = 17'h00000;
    module_pending = 8'h00;
    for (int i = 0; i < `CPR_SRC_COUNT; i++) begin
      module_mask[i] = module_enable[module_of(i)];
    end
    pending = interrupt_flags & source_enable & module_mask;
    for (int i = 0; i < `CPR_SRC_COUNT; i++) begin
      module_pending[module_of(i)] = module_pending[module_of(i)] | pending[i];
    end
  end

  // A flag sets whatever the enables say, and a set beats a same-cycle clear.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interrupt_flags <= 17'h00000;
    end else if (state == cpr_pkg::ST_RESET_HOLD) begin
      interrupt_flags <= 17'h00000;
    end else begin
      interrupt_flags <= (interrupt_flags & ~flag_clear) | source_event;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interrupt_request <= 1'b0;
      interrupt_source_identify <= 8'h00;
    end else begin
      interrupt_request <= global_enable && |pending;
      interrupt_source_identify <= module_pending;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interrupt_vector_address <= `CPR_VECTOR_RESET;
    end else if (state == cpr_pkg::ST_RESET_HOLD) begin
      interrupt_vector_address <= `CPR_VECTOR_RESET;
    end else if (vector_write) begin
      interrupt_vector_address <= vector_data;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      warm_len <= 17'h00000;
    end else begin
      warm_len <= state == cpr_pkg::ST_WARMUP ? warm_len + 17'h00001 : 17'h00000;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_warm_length: assert property (warm.done && !por_active |->
    warm_len == 17'(WARMUP_CYCLES)) else $error("warm-up length wrong");
  a_warm_gate: assert property (state == cpr_pkg::ST_WARMUP |=> !sys_tick)
    else $error("clock ran during warm-up");
  a_div_one: assert property (state == cpr_pkg::ST_RUN && sys_tick && !clock_config_write
    && !low_power_divide_enable && clock_divide_select == 2'h0 && $stable(state)
    |=> sys_tick || state != cpr_pkg::ST_RUN) else $error("divide by one broken");
  a_div256_gap: assert property (sys_tick && divide256_mode && !switchback_enable
    && !clock_config_write |=> !sys_tick [*8]) else $error("divide-256 too fast");
  a_switch_back: assert property (switchback_enable && divide256_mode && interrupt_request
    && state != cpr_pkg::ST_RESET_HOLD |=> !divide256_mode)
    else $error("switchback failed");
  a_stop_halts: assert property (state == cpr_pkg::ST_STOP |-> !osc_enable
    && !execution_enable ##1 !sys_tick) else $error("stop did not halt");
  a_stop_wake: assert property (state == cpr_pkg::ST_STOP && stop_wake
    |=> state == cpr_pkg::ST_WARMUP && warm.busy) else $error("stop wake missed");
  a_stop_display: assert property (state == cpr_pkg::ST_STOP |->
    rtc_run && display_run == !display_clock_source_select)
    else $error("32kHz users wrong in stop");
  a_flag_sets: assert property (|source_event && state != cpr_pkg::ST_RESET_HOLD
    |=> (interrupt_flags & $past(source_event)) == $past(source_event))
    else $error("flag not set");
  a_irq_global: assert property (!$past(global_enable) |-> !interrupt_request)
    else $error("request without global enable");
  a_vector_reset: assert property (state == cpr_pkg::ST_RESET_HOLD
    |=> interrupt_vector_address == 16'h0000) else $error("vector not cleared");
  a_pin_drive: assert property (state == cpr_pkg::ST_RUN && watchdog_reset_request
    |=> reset_pin_oe [*8]) else $error("pin not driven low");
  a_start_addr: assert property (exec_start |-> start_address == 16'h8000
    && $past(state) == cpr_pkg::ST_RESET_HOLD && execution_enable)
    else $error("bad start");
  a_pin_hold: assert property (state == cpr_pkg::ST_RESET_HOLD && !reset_pin_in
    |=> state == cpr_pkg::ST_RESET_HOLD) else $error("left reset early");
  c_stop_wake: cover property (state == cpr_pkg::ST_STOP ##1 state == cpr_pkg::ST_WARMUP);
  c_div256: cover property (divide256_mode && sys_tick);
  c_switch: cover property (divide256_mode && switchback_enable && interrupt_request);
  c_start: cover property (exec_start);
endmodule : clock_power_reset_control
`default_nettype wire

/* File: test/reset_pin_model.sv */
// Far-side model: pulled-up external reset wire and a core that counts restarts.
`timescale 1ns/10ps
`default_nettype none
module reset_pin_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic hold_low,
  input wire logic exec_start,
  output logic reset_pin_in,
  output int starts
);
  // --------------------------------------------------------------------------
  // Reset wire
  // --------------------------------------------------------------------------
  // The wire has a pull-up, so a released pin reads high and never its last value.
  assign reset_pin_in = reset_pin_oe ? reset_pin_out : !hold_low;
  // --------------------------------------------------------------------------
  // Core restarts
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      starts <= 0;
    end else if (exec_start) begin
      starts <= starts + 1;
    end
  end
endmodule : reset_pin_model
`default_nettype wire

/* File: test/test_clock_power_reset_control.sv */
// Self-checking testbench for the clock, power and reset controller.
`timescale 1ns/10ps
`default_nettype none
module test_clock_power_reset_control;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  // A short warm-up keeps the run brief; expectations derive from it.
  localparam int WARM = 16;
  logic clock, rstn, clock_config_write, low_power_divide_enable_in, switchback_enable;
  logic halt_request, display_clock_source_select, global_enable, vector_write;
  logic watchdog_reset_request, reset_pin_in, por_flag_clear, hold_low;
  logic [1:0] clock_divide_select_in, clock_divide_select;
  logic [16:0] source_event, source_enable, flag_clear, interrupt_flags;
  logic [7:0] module_enable, interrupt_source_identify;
  logic [15:0] vector_data, interrupt_vector_address, start_address;
  logic low_power_divide_enable, divide256_mode, sys_tick, execution_enable, cpu_reset;
  logic osc_enable, rtc_run, display_run, interrupt_request, exec_start;
  logic reset_pin_out, reset_pin_oe, por_flag;
  int n_mismatch, samples_checked, starts, gap, cnt, tks, s0;
  clock_power_reset_control #(.WARMUP_CYCLES(WARM)) dut (
    .clock, .rstn, .clock_config_write, .clock_divide_select_in, .low_power_divide_enable_in,
    .switchback_enable, .halt_request, .display_clock_source_select, .source_event,
    .source_enable, .module_enable, .global_enable, .flag_clear, .vector_write, .vector_data,
    .watchdog_reset_request, .reset_pin_in, .por_flag_clear, .clock_divide_select,
    .low_power_divide_enable, .divide256_mode, .sys_tick, .execution_enable, .cpu_reset,
    .osc_enable, .rtc_run, .display_run, .interrupt_flags, .interrupt_request,
    .interrupt_source_identify, .interrupt_vector_address, .exec_start, .start_address,
    .reset_pin_out, .reset_pin_oe, .por_flag
  );
  reset_pin_model far (
    .clock, .rstn, .reset_pin_out, .reset_pin_oe, .hold_low, .exec_start, .reset_pin_in, .starts
  );
  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task end_sim;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task chk(input logic ok);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t check %0d failed", $time, samples_checked);
    end
  endtask : chk
  task timeout;
    n_mismatch++;
    $display("ERROR %0t wait ran out", $time);
    end_sim();
  endtask : timeout
  // Counts cycles and stray ticks until execution resumes.
  task wait_run;
    cnt = 0;
    tks = 0;
    while (execution_enable !== 1'b1 && cnt < 3000) begin
      @(negedge clock);
      cnt++;
      if (sys_tick === 1'b1) tks++;
    end
    if (cnt >= 3000) timeout();
  endtask : wait_run
  // Measures the spacing from one system tick to the next.
  task meas;
    cnt = 0;
    while (sys_tick !== 1'b1 && cnt < 600) begin
      @(negedge clock);
      cnt++;
    end
    gap = 0;
    do begin
      @(negedge clock);
      gap++;
    end while (sys_tick !== 1'b1 && gap < 600);
    if (cnt >= 600 || gap >= 600) timeout();
  endtask : meas
  task cfg(input logic [1:0] s, input logic l);
    @(posedge clock);
    clock_divide_select_in <= s;
    low_power_divide_enable_in <= l;
    clock_config_write <= 1'b1;
    @(posedge clock) clock_config_write <= 1'b0;
    @(negedge clock);
  endtask : cfg
  task ev(input int i);
    @(posedge clock) source_event <= 17'h00001 << i;
    @(posedge clock) source_event <= 17'h00000;
    repeat (2) @(negedge clock);
  endtask : ev
  task clr(input logic [16:0] m);
    @(posedge clock) flag_clear <= m;
    @(posedge clock) flag_clear <= 17'h00000;
    repeat (2) @(negedge clock);
  endtask : clr
  function automatic int mod_of(input int i);
    return i == 0 ? 0 : i < 4 ? 1 : i < 6 ? 2 : i < 8 ? 3 : i < 10 ? 4 : i == 10 ? 5 : i < 13 ? 6 : 7;
  endfunction : mod_of
  // --------------------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    {rstn, clock_config_write, low_power_divide_enable_in, switchback_enable} = 4'h0;
    {halt_request, display_clock_source_select, global_enable, vector_write} = 4'h0;
    {watchdog_reset_request, por_flag_clear, hold_low} = 3'h0;
    clock_divide_select_in = 2'h0;
    {source_event, source_enable, flag_clear} = {3{17'h00000}};
    module_enable = 8'h00;
    vector_data = 16'h0000;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (16) @(posedge clock);
    @(negedge clock);
    chk(cpu_reset === 1'b1 && execution_enable === 1'b0 && osc_enable === 1'b1);
    chk(reset_pin_oe === 1'b1 && reset_pin_in === 1'b0 && por_flag === 1'b1);
    chk(interrupt_vector_address === 16'h0000 && interrupt_flags === 17'h00000);
    chk(clock_divide_select === 2'h0 && low_power_divide_enable === 1'b0);
    @(posedge clock) rstn <= 1'b1;
    wait_run();
    chk(cnt >= WARM && tks == 0);
    repeat (2) @(negedge clock);
    chk(starts == 1 && start_address === 16'h8000);
    for (int s = 0; s < 4; s++) begin
      cfg(2'(s), 1'b0);
      meas();
      meas();
      chk(gap == (1 << s));
    end
    cfg(2'h0, 1'b1);
    chk(divide256_mode === 1'b1);
    meas();
    meas();
    chk(gap == 256);
    // Every source with all enables on lands in its own module.
    @(posedge clock) {source_enable, module_enable, global_enable} <= {17'h1FFFF, 8'hFF, 1'b1};
    for (int i = 0; i < 17; i++) begin
      ev(i);
      chk(interrupt_flags === (17'h00001 << i));
      chk(interrupt_source_identify === (8'h01 << mod_of(i)));
      clr(17'h1FFFF);
    end
    @(posedge clock) {source_enable, module_enable, global_enable} <= {17'h00000, 8'h00, 1'b0};
    ev(6);
    chk(interrupt_flags[6] === 1'b1 && interrupt_request === 1'b0);
    for (int k = 0; k < 8; k++) begin
      @(posedge clock);
      source_enable <= {10'h000, k[0], 6'h00};
      module_enable <= {4'h0, k[1], 3'h0};
      global_enable <= k[2];
      repeat (3) @(negedge clock);
      chk(interrupt_request === (k == 7));
    end
    chk(divide256_mode === 1'b1);
    @(posedge clock) switchback_enable <= 1'b1;
    repeat (4) @(negedge clock);
    chk(divide256_mode === 1'b0 && low_power_divide_enable === 1'b0);
    clr(17'h00040);
    chk(interrupt_request === 1'b0 && interrupt_flags === 17'h00000);
    @(posedge clock) {vector_data, vector_write} <= {16'hA5C3, 1'b1};
    @(posedge clock) vector_write <= 1'b0;
    @(negedge clock);
    chk(interrupt_vector_address === 16'hA5C3);
    cfg(2'h2, 1'b0);
    @(posedge clock) source_enable <= 17'h00002;
    // Wake by external interrupt, by alarm, then by the reset pin.
    for (int w = 0; w < 3; w++) begin
      s0 = starts;
      @(posedge clock) display_clock_source_select <= w[0];
      @(posedge clock) halt_request <= 1'b1;
      @(posedge clock) halt_request <= 1'b0;
      repeat (3) @(negedge clock);
      chk(osc_enable === 1'b0 && execution_enable === 1'b0 && sys_tick === 1'b0);
      chk(rtc_run === 1'b1 && display_run === !w[0]);
      ev(3);
      chk(osc_enable === 1'b0);
      if (w < 2) begin
        ev(w == 0 ? 1 : 4);
        wait_run();
        chk(cnt >= WARM && tks == 0 && starts == s0);
      end else begin
        @(posedge clock) hold_low <= 1'b1;
        repeat (40) @(negedge clock);
        chk(osc_enable === 1'b1 && cpu_reset === 1'b1 && execution_enable === 1'b0);
        @(posedge clock) hold_low <= 1'b0;
        wait_run();
        repeat (2) @(negedge clock);
        chk(starts == s0 + 1 && tks == 0);
      end
      meas();
      meas();
      chk(gap == (w < 2 ? 4 : 1));
      clr(17'h1FFFF);
    end
    s0 = starts;
    @(posedge clock) por_flag_clear <= 1'b1;
    @(posedge clock) por_flag_clear <= 1'b0;
    @(posedge clock) watchdog_reset_request <= 1'b1;
    @(posedge clock) watchdog_reset_request <= 1'b0;
    @(negedge clock);
    chk(cpu_reset === 1'b1 && reset_pin_oe === 1'b1 && reset_pin_in === 1'b0);
    wait_run();
    repeat (2) @(negedge clock);
    chk(starts == s0 + 1 && start_address === 16'h8000 && por_flag === 1'b0);
    chk(interrupt_vector_address === 16'h0000 && reset_pin_oe === 1'b0);
    @(posedge clock) hold_low <= 1'b1;
    repeat (20) @(negedge clock);
    chk(cpu_reset === 1'b1 && execution_enable === 1'b0 && osc_enable === 1'b1);
    @(posedge clock) hold_low <= 1'b0;
    wait_run();
    repeat (2) @(negedge clock);
    chk(starts == s0 + 2 && por_flag === 1'b0);
    cfg(2'h3, 1'b0);
    @(posedge clock) rstn <= 1'b0;
    repeat (3) @(negedge clock);
    chk(por_flag === 1'b1 && clock_divide_select === 2'h0 && cpu_reset === 1'b1);
    @(posedge clock) rstn <= 1'b1;
    wait_run();
    chk(cnt >= WARM);
    end_sim();
  end
endmodule : test_clock_power_reset_control
`default_nettype wire
